// [logic/pdbg_pkg.sv]
// Purpose: Shared constants and types for the physical-layer debug register bank
// Assumes: 40 MHz core clock, one instance per station of four ports
// Notes: Register offsets are byte addresses on the management port
`default_nettype none
package pdbg_pkg;
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned NPORTS = 4;

  // Least times round up to whole cycles, never below one
  function automatic int unsigned pdbg_cyc_ceil(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c == 0) ? 1 : c;
  endfunction : pdbg_cyc_ceil

  localparam logic [11:0] STATUS_OFS = 12'h254;
  localparam logic [11:0] CONTROL_OFS = 12'h258;
  localparam logic [11:0] INJECT_OFS = 12'h25C;

  localparam int unsigned LPF_LSB = 0;
  localparam int unsigned SPEED_LSB = 8;
  localparam int unsigned PSEL_LSB = 12;
  localparam int unsigned MCERR_LSB = 16;
  localparam int unsigned MCLOCK_BIT = 23;
  localparam int unsigned LSEL_LSB = 24;
  localparam int unsigned EXTLB_LSB = 0;
  localparam int unsigned RXDET_LSB = 8;
  localparam int unsigned TXIDLE_LSB = 18;
  localparam int unsigned INJ_GROUP = 4;
  localparam int unsigned INJ_TLP_LSB = 2;

  localparam logic [3:0] LPF_RST = 4'h0;
  localparam logic [2:0] PSEL_RST = 3'h0;
  localparam logic [3:0] LSEL_RST = 4'h0;
  localparam logic [3:0] EXTLB_RST = 4'h0;
  localparam logic [3:0] RXDET_RST = 4'h0;
  localparam logic [1:0] TXIDLE_RST = 2'h0;
  localparam logic [15:0] INJ_RST = 16'h0000;

  localparam logic [1:0] SPEED_LOW = 2'h0;
  localparam logic [1:0] SPEED_FLOAT = 2'h1;
  localparam logic [1:0] SPEED_HIGH = 2'h2;

  localparam logic [1:0] BIT_OFF = 2'h0;
  localparam logic [1:0] BIT_US = 2'h1;
  localparam logic [1:0] BIT_MS = 2'h2;
  localparam logic [1:0] BIT_DLLP = 2'h3;

  localparam int unsigned TXIDLE0_NS = 20;
  localparam int unsigned TXIDLE1_NS = 30;
  localparam int unsigned TXIDLE2_NS = 40;
  localparam int unsigned TXIDLE3_NS = 80;
  localparam int unsigned TXIDLE0_CYC = pdbg_cyc_ceil(TXIDLE0_NS);
  localparam int unsigned TXIDLE1_CYC = pdbg_cyc_ceil(TXIDLE1_NS);
  localparam int unsigned TXIDLE2_CYC = pdbg_cyc_ceil(TXIDLE2_NS);
  localparam int unsigned TXIDLE3_CYC = pdbg_cyc_ceil(TXIDLE3_NS);

  localparam int unsigned USEC_NS = 1000;
  localparam int unsigned MSEC_NS = 1000000;
  localparam int unsigned RXDET_WAIT_NS = 12000000;
  localparam int unsigned USEC_CYC = USEC_NS / CLK_NS;
  localparam int unsigned MSEC_CYC = MSEC_NS / CLK_NS;
  localparam int unsigned RXDET_CYC = RXDET_WAIT_NS / CLK_NS;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pdbg_mgmt_req_type;
endpackage : pdbg_pkg
`default_nettype wire

// [logic/pdbg_ctrl.sv]
// Purpose: Per-station physical-layer debug, test and error injection registers
// Assumes: Port-side event inputs are on mclk; straps are asynchronous pins
// Notes: Management reads and writes answer one cycle after the request
`default_nettype none
module pdbg_ctrl #(
  parameter int unsigned MS_CYCLES = pdbg_pkg::MSEC_CYC,
  parameter int unsigned RXDET_CYCLES = pdbg_pkg::RXDET_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire pdbg_pkg::pdbg_mgmt_req_type mgmt_req,
  output logic [31:0] mgmt_rdata,
  output logic mgmt_ack,
  input wire logic [1:0] speed_select_strap,
  input wire logic [3:0] station_port_config_strap,
  input wire logic [3:0] lpbk_fail_evt,
  input wire logic [3:0] lpbk_master_rdy,
  input wire logic [27:0] mc_err_lanes0,
  input wire logic [27:0] mc_err_lanes1,
  input wire logic [3:0] mc_lock_lanes0,
  input wire logic [3:0] mc_lock_lanes1,
  input wire logic [3:0] rxdet_partial,
  input wire logic [3:0] dllp_tx,
  input wire logic [3:0] tlp_tx,
  output logic [3:0] ext_loopback_en,
  output logic [3:0] lpbk_after_retry,
  output logic [3:0] rxdet_retry,
  output logic [3:0] rxdet_to_polling,
  output logic [3:0] rxdet_waiting,
  output logic [2:0] tx_idle_min_cyc,
  output logic [3:0] bit_err_inj,
  output logic [3:0] dllp_err_inj,
  output logic [3:0] tlp_err_inj
);
  localparam int unsigned DW = $clog2(MS_CYCLES + 1);
  localparam int unsigned RW = $clog2(RXDET_CYCLES + 1);
  localparam logic [DW-1:0] US_LAST = DW'(pdbg_pkg::USEC_CYC - 1);
  localparam logic [DW-1:0] MS_LAST = DW'(MS_CYCLES - 1);
  localparam logic [RW-1:0] RX_LAST = RW'(RXDET_CYCLES - 1);

  logic wr_stat, wr_ctrl, wr_inj;
  logic [31:0] wd;
  logic [3:0] lpf_q, lsel_q, extlb_q, rxdis_q;
  logic [2:0] psel_q;
  logic [1:0] txidle_q;
  logic [15:0] inj_q;
  logic [1:0] strap_s1_q, strap_s2_q, speed_q;
  logic strap_done_q;
  logic [1:0] strap_arm_q;
  logic [3:0] cfg_s1_q, cfg_s2_q;
  logic [1:0] speed_rd;
  logic [6:0] mcerr_rd;
  logic mclock_rd;
  logic [31:0] rdata_d;
  logic [3:0] dllp_hit;
  logic [DW-1:0] div_q [4];
  logic [RW-1:0] rxt_q [4];
  logic [1:0] tlpc_q [4];

  assign wd = mgmt_req.wdata;
  assign wr_stat = mgmt_req.valid && mgmt_req.wr && (mgmt_req.addr == pdbg_pkg::STATUS_OFS);
  assign wr_ctrl = mgmt_req.valid && mgmt_req.wr && (mgmt_req.addr == pdbg_pkg::CONTROL_OFS);
  assign wr_inj = mgmt_req.valid && mgmt_req.wr && (mgmt_req.addr == pdbg_pkg::INJECT_OFS);

  function automatic logic [1:0] inj_bit(input logic [15:0] v, input int unsigned p);
    return v[p*pdbg_pkg::INJ_GROUP +: 2];
  endfunction : inj_bit

  function automatic logic [1:0] inj_tlp(input logic [15:0] v, input int unsigned p);
    return v[p*pdbg_pkg::INJ_GROUP + pdbg_pkg::INJ_TLP_LSB +: 2];
  endfunction : inj_tlp

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lpf_q <= pdbg_pkg::LPF_RST;
    end else begin
      // Set wins over a clear landing in the same cycle
      lpf_q <= (lpf_q & ~(wr_stat ? wd[pdbg_pkg::LPF_LSB +: 4] : 4'h0)) | lpbk_fail_evt;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      psel_q <= pdbg_pkg::PSEL_RST;
      lsel_q <= pdbg_pkg::LSEL_RST;
    end else if (wr_stat) begin
      psel_q <= wd[pdbg_pkg::PSEL_LSB +: 3];
      lsel_q <= wd[pdbg_pkg::LSEL_LSB +: 4];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      extlb_q <= pdbg_pkg::EXTLB_RST;
      rxdis_q <= pdbg_pkg::RXDET_RST;
      txidle_q <= pdbg_pkg::TXIDLE_RST;
    end else if (wr_ctrl) begin
      extlb_q <= wd[pdbg_pkg::EXTLB_LSB +: 4];
      rxdis_q <= wd[pdbg_pkg::RXDET_LSB +: 4];
      txidle_q <= wd[pdbg_pkg::TXIDLE_LSB +: 2];
    end
  end

  // Strap synchronised, caught once after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_q <= 2'h0;
      strap_s2_q <= 2'h0;
      strap_arm_q <= 2'h0;
      speed_q <= pdbg_pkg::SPEED_LOW;
      strap_done_q <= 1'b0;
    end else begin
      strap_s1_q <= speed_select_strap;
      strap_s2_q <= strap_s1_q;
      // Catch only once the second stage holds a sampled strap
      strap_arm_q <= {strap_arm_q[0], 1'b1};
      if (strap_arm_q[1] && !strap_done_q) begin
        speed_q <= strap_s2_q;
        strap_done_q <= 1'b1;
      end
    end
  end

  // Port enable straps are pins too, so they pass two stages first
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_s1_q <= 4'h0;
      cfg_s2_q <= 4'h0;
    end else begin
      cfg_s1_q <= station_port_config_strap;
      cfg_s2_q <= cfg_s1_q;
    end
  end

  // DLLP corruption consumed by the next DLLP
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      dllp_hit[p] = dllp_tx[p] && (inj_bit(inj_q, p) == pdbg_pkg::BIT_DLLP);
    end
  end

  // Injection groups, four bits per port
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      inj_q <= pdbg_pkg::INJ_RST;
    end else begin
      for (int p = 0; p < 4; p++) begin
        if (wr_inj) begin
          inj_q[p*pdbg_pkg::INJ_GROUP +: 4] <= wd[p*pdbg_pkg::INJ_GROUP +: 4];
        end else if (dllp_hit[p]) begin
          inj_q[p*pdbg_pkg::INJ_GROUP +: 2] <= pdbg_pkg::BIT_OFF;
        end
      end
    end
  end

  // Per-port divider, restarted on field change
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < 4; p++) begin
        div_q[p] <= '0;
      end
      bit_err_inj <= 4'h0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        bit_err_inj[p] <= 1'b0;
        if (wr_inj && wd[p*pdbg_pkg::INJ_GROUP +: 2] != inj_bit(inj_q, p)) begin
          div_q[p] <= '0;
        end else if ((inj_bit(inj_q, p) == pdbg_pkg::BIT_US && div_q[p] == US_LAST) ||
                     (inj_bit(inj_q, p) == pdbg_pkg::BIT_MS && div_q[p] == MS_LAST)) begin
          div_q[p] <= '0;
          bit_err_inj[p] <= 1'b1;
        end else if (inj_bit(inj_q, p) == pdbg_pkg::BIT_US ||
                     inj_bit(inj_q, p) == pdbg_pkg::BIT_MS) begin
          div_q[p] <= div_q[p] + DW'(1);
        end else begin
          div_q[p] <= '0;
        end
      end
    end
  end

  // TLP corruption every first, second or third
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < 4; p++) begin
        tlpc_q[p] <= 2'h0;
      end
      tlp_err_inj <= 4'h0;
      dllp_err_inj <= 4'h0;
    end else begin
      dllp_err_inj <= dllp_hit;
      for (int p = 0; p < 4; p++) begin
        tlp_err_inj[p] <= 1'b0;
        if (wr_inj && wd[p*pdbg_pkg::INJ_GROUP + pdbg_pkg::INJ_TLP_LSB +: 2] !=
            inj_tlp(inj_q, p)) begin
          tlpc_q[p] <= 2'h0;
        end else if (tlp_tx[p] && inj_tlp(inj_q, p) != 2'h0) begin
          tlp_err_inj[p] <= (tlpc_q[p] == 2'h0);
          tlpc_q[p] <= (tlpc_q[p] == inj_tlp(inj_q, p) - 2'h1) ? 2'h0 : tlpc_q[p] + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < 4; p++) begin
        rxt_q[p] <= '0;
      end
      rxdet_waiting <= 4'h0;
      rxdet_retry <= 4'h0;
      rxdet_to_polling <= 4'h0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        rxdet_retry[p] <= 1'b0;
        rxdet_to_polling[p] <= 1'b0;
        if (rxdet_waiting[p]) begin
          if (rxt_q[p] == RX_LAST) begin
            rxdet_waiting[p] <= 1'b0;
            rxdet_retry[p] <= 1'b1;
          end
          rxt_q[p] <= rxt_q[p] + RW'(1);
        end else if (rxdet_partial[p]) begin
          if (rxdis_q[p]) begin
            rxdet_to_polling[p] <= 1'b1;
          end else begin
            rxdet_waiting[p] <= 1'b1;
            rxt_q[p] <= '0;
          end
        end
      end
    end
  end

  // Port position picks bits within the station
  always_comb begin
    speed_rd = 2'h0;
    mcerr_rd = 7'h00;
    mclock_rd = 1'b0;
    // Reserved or disabled selections read zero
    if (psel_q < 3'h4 && cfg_s2_q[psel_q[1:0]]) begin
      speed_rd = speed_q;
      // Lane select picks the lane set
      mcerr_rd = lsel_q[psel_q[1:0]] ? mc_err_lanes1[psel_q[1:0]*7 +: 7] :
                                       mc_err_lanes0[psel_q[1:0]*7 +: 7];
      mclock_rd = lsel_q[psel_q[1:0]] ? mc_lock_lanes1[psel_q[1:0]] :
                                        mc_lock_lanes0[psel_q[1:0]];
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (mgmt_req.valid && !mgmt_req.wr) begin
      case (mgmt_req.addr)
        pdbg_pkg::STATUS_OFS: begin
          rdata_d[pdbg_pkg::LPF_LSB +: 4] = lpf_q;
          rdata_d[pdbg_pkg::SPEED_LSB +: 2] = speed_rd;
          rdata_d[pdbg_pkg::PSEL_LSB +: 3] = psel_q;
          rdata_d[pdbg_pkg::MCERR_LSB +: 7] = mcerr_rd;
          rdata_d[pdbg_pkg::MCLOCK_BIT] = mclock_rd;
          rdata_d[pdbg_pkg::LSEL_LSB +: 4] = lsel_q;
        end
        pdbg_pkg::CONTROL_OFS: begin
          rdata_d[pdbg_pkg::EXTLB_LSB +: 4] = extlb_q;
          rdata_d[pdbg_pkg::RXDET_LSB +: 4] = rxdis_q;
          rdata_d[pdbg_pkg::TXIDLE_LSB +: 2] = txidle_q;
        end
        pdbg_pkg::INJECT_OFS: begin
          rdata_d[15:0] = inj_q;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_rdata <= 32'h0000_0000;
      mgmt_ack <= 1'b0;
      ext_loopback_en <= 4'h0;
      lpbk_after_retry <= 4'h0;
      tx_idle_min_cyc <= 3'(pdbg_pkg::TXIDLE0_CYC);
    end else begin
      mgmt_rdata <= rdata_d;
      mgmt_ack <= mgmt_req.valid;
      // Loopback enable to the training logic
      ext_loopback_en <= extlb_q;
      lpbk_after_retry <= lpf_q & lpbk_master_rdy;
      case (txidle_q)
        2'h0: tx_idle_min_cyc <= 3'(pdbg_pkg::TXIDLE0_CYC);
        2'h1: tx_idle_min_cyc <= 3'(pdbg_pkg::TXIDLE1_CYC);
        2'h2: tx_idle_min_cyc <= 3'(pdbg_pkg::TXIDLE2_CYC);
        default: tx_idle_min_cyc <= 3'(pdbg_pkg::TXIDLE3_CYC);
      endcase
    end
  end
endmodule : pdbg_ctrl
`default_nettype wire

// [test/pdbg_ctrl_assertions.sv]
// Purpose: Port-level checks of the station debug register bank
// Assumes: Single mclk domain, shortened detect wait
// Notes: Bound to every pdbg_ctrl instance
`default_nettype none
module pdbg_ctrl_assertions #(
  parameter int unsigned RXDET_CYCLES = 50
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire pdbg_pkg::pdbg_mgmt_req_type mgmt_req,
  input wire logic mgmt_ack,
  input wire logic [3:0] lpbk_master_rdy,
  input wire logic [3:0] rxdet_partial,
  input wire logic [3:0] dllp_tx,
  input wire logic [3:0] tlp_tx,
  input wire logic [3:0] lpbk_after_retry,
  input wire logic [3:0] rxdet_retry,
  input wire logic [3:0] rxdet_to_polling,
  input wire logic [3:0] rxdet_waiting,
  input wire logic [2:0] tx_idle_min_cyc,
  input wire logic [3:0] dllp_err_inj,
  input wire logic [3:0] tlp_err_inj
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_ack; mgmt_req.valid |=> mgmt_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_ack_src; mgmt_ack |-> $past(mgmt_req.valid); endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack without request");
  property p_lbr; (lpbk_after_retry & ~$past(lpbk_master_rdy)) == 4'h0; endproperty
  a_lbr: assert property (p_lbr) else $error("loopback retry without ready");
  property p_poll; (rxdet_to_polling & ~$past(rxdet_partial)) == 4'h0; endproperty
  a_poll: assert property (p_poll) else $error("polling without partial detect");
  property p_wait; $rose(rxdet_waiting[1]) |-> $past(rxdet_partial[1]); endproperty
  a_wait: assert property (p_wait) else $error("wait without partial detect");
  property p_hold; $rose(rxdet_waiting[1]) |-> rxdet_waiting[1] [*8]; endproperty
  a_hold: assert property (p_hold) else $error("wait dropped early");
  property p_retry;
    $rose(rxdet_waiting[1]) |-> ##RXDET_CYCLES (rxdet_retry[1] && !rxdet_waiting[1]);
  endproperty
  a_retry: assert property (p_retry) else $error("retry not at end of wait");
  property p_dllp; (dllp_err_inj & ~$past(dllp_tx)) == 4'h0; endproperty
  a_dllp: assert property (p_dllp) else $error("DLLP error without DLLP");
  property p_tlp; (tlp_err_inj & ~$past(tlp_tx)) == 4'h0; endproperty
  a_tlp: assert property (p_tlp) else $error("TLP error without TLP");
  property p_idle; tx_idle_min_cyc inside {3'h1, 3'h2, 3'h4}; endproperty
  a_idle: assert property (p_idle) else $error("idle time off the list");
  c_retry: cover property (rxdet_retry[1]);
  c_dllp: cover property (dllp_err_inj[1]);
  c_tlp: cover property (tlp_err_inj[0]);
endmodule : pdbg_ctrl_assertions
bind pdbg_ctrl pdbg_ctrl_assertions #(.RXDET_CYCLES(RXDET_CYCLES)) u_chk (.mclk, .rst_n,
  .mgmt_req, .mgmt_ack, .lpbk_master_rdy, .rxdet_partial, .dllp_tx, .tlp_tx, .lpbk_after_retry,
  .rxdet_retry, .rxdet_to_polling, .rxdet_waiting, .tx_idle_min_cyc, .dllp_err_inj, .tlp_err_inj);
`default_nettype wire

// [test/pdbg_link_model.sv]
// Purpose: Link partner traffic source for the debug bank
// Assumes: One TLP and one DLLP per three cycles on each enabled port
// Notes: Changes just after the rising edge, like a real transmitter
`default_nettype none
module pdbg_link_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] go,
  output logic [3:0] dllp_tx,
  output logic [3:0] tlp_tx
);
  logic [1:0] ph_q;
  // Odd period keeps TLP and DLLP pulses apart
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) ph_q <= 2'h0;
    else ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
  end
  assign tlp_tx = go & {4{ph_q == 2'h0}};
  assign dllp_tx = go & {4{ph_q == 2'h1}};
endmodule : pdbg_link_model
`default_nettype wire

// [test/test_pcie_phy_debug_control.sv]
// Purpose: Self-checking bench for the station debug register bank
// Assumes: 40 MHz mclk; long waits shortened by parameter
// Notes: Inputs move on the falling edge; pulse counts taken at the rising edge
`default_nettype none
module test_pcie_phy_debug_control;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned RX = 50;
  localparam logic [11:0] ST = pdbg_pkg::STATUS_OFS;
  localparam logic [11:0] CT = pdbg_pkg::CONTROL_OFS;
  localparam logic [11:0] IJ = pdbg_pkg::INJECT_OFS;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cnt_en = 1'b0;
  logic [1:0] strap = 2'h2;
  pdbg_pkg::pdbg_mgmt_req_type req = '0;
  logic [31:0] rdata;
  logic ack;
  logic [3:0] fail = 4'h0, rdy = 4'h0, part = 4'h0, go = 4'h0, lock0 = 4'h0, lock1 = 4'h0;
  logic [27:0] err0 = 28'h0, err1 = 28'h0;
  logic [3:0] dllp, tlp, extlb, lbr, retry, topoll, waiting, bit_inj, dllp_inj, tlp_inj;
  logic [2:0] idle;
  int n_fail = 0, samples_checked = 0, cyc = 0;
  int ntx[4] = '{default: 0}, nte[4] = '{default: 0};
  int nbit[4] = '{default: 0}, ndl[4] = '{default: 0};
  pdbg_ctrl #(.MS_CYCLES(100), .RXDET_CYCLES(RX)) dut (.mclk(mclk), .rst_n(rst_n),
    .mgmt_req(req), .mgmt_rdata(rdata), .mgmt_ack(ack), .speed_select_strap(strap),
    .station_port_config_strap(4'hB), .lpbk_fail_evt(fail), .lpbk_master_rdy(rdy),
    .mc_err_lanes0(err0), .mc_err_lanes1(err1), .mc_lock_lanes0(lock0), .mc_lock_lanes1(lock1),
    .rxdet_partial(part), .dllp_tx(dllp), .tlp_tx(tlp), .ext_loopback_en(extlb),
    .lpbk_after_retry(lbr), .rxdet_retry(retry), .rxdet_to_polling(topoll),
    .rxdet_waiting(waiting), .tx_idle_min_cyc(idle), .bit_err_inj(bit_inj),
    .dllp_err_inj(dllp_inj), .tlp_err_inj(tlp_inj));
  pdbg_link_model u_link (.mclk(mclk), .rst_n(rst_n), .go(go), .dllp_tx(dllp), .tlp_tx(tlp));
  initial forever #12.5 mclk = ~mclk;
  task automatic results();
    $display("TB: checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // Hang guard, well past the few hundred cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end
  always @(posedge mclk) begin
    for (int i = 0; i < 4; i++) if (cnt_en) begin
      ntx[i] += tlp[i];
      nte[i] += tlp_inj[i];
      nbit[i] += bit_inj[i];
      ndl[i] += dllp_inj[i];
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(negedge mclk);
    req = {1'b1, w, a, d};
    @(negedge mclk);
    chk(ack, 32'h1);
    q = rdata;
    req = '0;
  endtask : acc
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd
  task automatic t_reset();
    rd(ST, 32'h0000_0200);
    rd(CT, 32'h0);
    rd(IJ, 32'h0);
    rd(12'h260, 32'h0);
  endtask : t_reset
  task automatic t_flags();
    @(negedge mclk);
    fail = 4'h5;
    rdy = 4'h1;
    @(negedge mclk);
    fail = 4'h0;
    @(negedge mclk);
    chk(lbr, 32'h1);
    rd(ST, 32'h0000_0205);
    wr(ST, 32'h1);
    rd(ST, 32'h0000_0204);
    chk(lbr, 32'h0);
    wr(ST, 32'h4);
    rdy = 4'h0;
    // Event and clear of the same flag in one cycle: the event wins
    @(negedge mclk);
    req = {1'b1, 1'b1, ST, 32'h2};
    fail = 4'h2;
    @(negedge mclk);
    chk(ack, 32'h1);
    req = '0;
    fail = 4'h0;
    rd(ST, 32'h0000_0202);
    wr(ST, 32'h2);
    rd(ST, 32'h0000_0200);
  endtask : t_flags
  task automatic t_select();
    logic [6:0] e;
    logic lk, s, en;
    logic [1:0] sp;
    err0 = 28'h0000895;
    err1 = 28'h660116A;
    lock0 = 4'h2;
    lock1 = 4'h8;
    for (int p = 0; p < 5; p++) for (int k = 0; k < 2; k++) begin
      s = k[0];
      en = (p < 4) && (p != 2);
      sp = en ? 2'h2 : 2'h0;
      e = !en ? 7'h0 : s ? err1[7*p +: 7] : err0[7*p +: 7];
      lk = en && (s ? lock1[p] : lock0[p]);
      wr(ST, {4'h0, {4{s}}, 9'h0, p[2:0], 12'h0});
      rd(ST, {4'h0, {4{s}}, lk, e, 1'b0, p[2:0], 2'h0, sp, 8'h0});
    end
  endtask : t_select
  task automatic t_ctrl();
    logic [2:0] ex[4] = '{3'h1, 3'h2, 3'h2, 3'h4};
    wr(CT, 32'hFFFE_FFFF);
    rd(CT, 32'h000C_0F0F);
    chk(extlb, 32'hF);
    for (int c = 0; c < 4; c++) begin
      wr(CT, {12'h0, c[1:0], 18'h00D0F});
      @(negedge mclk);
      chk(idle, ex[c]);
    end
    @(negedge mclk);
    part = 4'h3;
    @(negedge mclk);
    part = 4'h0;
    chk(topoll, 32'h1);
    chk(waiting, 32'h2);
    repeat (RX) @(negedge mclk);
    chk(retry, 32'h2);
    chk(waiting, 32'h0);
  endtask : t_ctrl
  task automatic t_inject();
    wr(IJ, 32'h0000_16BC);
    go = 4'h7;
    cnt_en = 1'b1;
    repeat (187) @(negedge mclk);
    go = 4'h0;
    repeat (3) @(negedge mclk);
    cnt_en = 1'b0;
    chk(nte[0], (ntx[0] + 2) / 3);
    chk(nte[1], (ntx[1] + 1) / 2);
    chk(nte[2], ntx[2]);
    chk(ndl[1], 32'h1);
    chk(nbit[3], 32'h4);
    chk(nbit[2], 32'h1);
    chk(nbit[0] + nbit[1] + ndl[0] + ndl[2], 32'h0);
    rd(IJ, 32'h0000_168C);
  endtask : t_inject
  task automatic t_rerun();
    err0 = 28'h0;
    err1 = 28'h0;
    lock0 = 4'h0;
    lock1 = 4'h0;
    @(negedge mclk);
    rst_n = 1'b0;
    strap = 2'h1;
    repeat (3) @(negedge mclk);
    chk(idle, 32'h1);
    chk(extlb, 32'h0);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    rd(ST, 32'h0000_0100);
    rd(CT, 32'h0);
    rd(IJ, 32'h0);
    chk(idle, 32'h1);
    // Strap is caught once; a later change must not show
    strap = 2'h0;
    repeat (4) @(negedge mclk);
    rd(ST, 32'h0000_0100);
  endtask : t_rerun
  initial begin
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_reset();
    t_flags();
    t_select();
    t_ctrl();
    t_inject();
    t_rerun();
    results();
  end
endmodule : test_pcie_phy_debug_control
`default_nettype wire
